// [src/step_motion_consts.vh]
// constants for the stepper motion command block
`ifndef STEP_MOTION_CONSTS_VH
`define STEP_MOTION_CONSTS_VH
`define MCLK_HZ 40000000
`define TICK_US 1000
`define ADDR_CTRL 8'h00
`define ADDR_RXDATA 8'h04
`define ADDR_TXDATA 8'h08
`define ADDR_STATUS 8'h0C
`define ADDR_POS 8'h10
`define ADDR_BEGIN_VEL 8'h14
`define ADDR_END_VEL 8'h18
`define ADDR_SLOPE 8'h1C
`define ADDR_BOARD 8'h20
`define CTRL_RT_BIT 0
`define CTRL_HWLIM_BIT 1
`define CTRL_HOMEDIS_BIT 2
`define CTRL_RESET 3'h0
`define BOARD_RESET 16'h3061
`define BEGIN_RESET 16'h0010
`define END_RESET 16'h0100
`define SLOPE_RESET 16'h0004
`define CH_CR 8'h0D
`define CH_PLUS 8'h2B
`define CH_MINUS 8'h2D
`define CH_Y 8'h59
`define CH_N 8'h4E
`define CH_S 8'h53
`define CH_ZERO 8'h30
`define CH_NINE 8'h39
`define CH_A_UP 8'h41
`define CMD_MOVE 8'h4D
`define CMD_GETPOS 8'h6D
`define CMD_REL 8'h52
`define CMD_CONT 8'h43
`define CMD_HOME 8'h4E
`define CMD_ABORT 8'h41
`define ST_READY 8'h52
`define ST_BUSY 8'h62
`define ST_UPDATE 8'h75
`define ST_ZEROED 8'h73
`define NIB_DIGITS 4'h8
`define VEL_W 16
`define PHASE_W 24
`endif

// [src/step_ramp.v]
// velocity ramp and step pulse generator
`timescale 1ns/1ps
`include "step_motion_consts.vh"
module step_ramp (
  input wire i_mclk,
  input wire i_reset_n,
  input wire i_run,
  input wire i_tick,
  input wire [`VEL_W-1:0] i_begin,
  input wire [`VEL_W-1:0] i_end,
  input wire [`VEL_W-1:0] i_slope,
  output reg o_step,
  output wire o_at_speed
);
  reg [`VEL_W-1:0] vel_reg;
  reg [`PHASE_W-1:0] phase_reg;
  reg run_d_reg;
  wire [`PHASE_W:0] phase_sum;
  wire [`VEL_W:0] up;
  wire [`VEL_W:0] down;

  assign phase_sum = {1'b0, phase_reg} + {{(`PHASE_W-`VEL_W+1){1'b0}}, vel_reg};
  assign up = {1'b0, vel_reg} + {1'b0, i_slope};
  assign down = {1'b0, vel_reg} - {1'b0, i_slope};
  assign o_at_speed = (vel_reg == i_end);

  always @(posedge i_mclk)
  begin
    if (!i_reset_n)
    begin
      vel_reg <= {`VEL_W{1'b0}};
      phase_reg <= {`PHASE_W{1'b0}};
      run_d_reg <= 1'b0;
      o_step <= 1'b0;
    end
    else
    begin
      run_d_reg <= i_run;
      o_step <= 1'b0;
      if (!i_run)
      begin
        phase_reg <= {`PHASE_W{1'b0}};
      end
      else if (!run_d_reg)
      begin
        // every move starts from the begin velocity
        vel_reg <= i_begin;
      end
      else
      begin
        phase_reg <= phase_sum[`PHASE_W-1:0];
        o_step <= phase_sum[`PHASE_W];
        // slope applied once per tick, clamped at the end velocity
        if (i_tick && vel_reg < i_end)
          vel_reg <= (up[`VEL_W] || up[`VEL_W-1:0] > i_end) ? i_end : up[`VEL_W-1:0];
        else if (i_tick && vel_reg > i_end)
          vel_reg <= (down[`VEL_W] || down[`VEL_W-1:0] < i_end) ? i_end : down[`VEL_W-1:0];
      end
    end
  end
endmodule // step_ramp

// [src/step_motion.v]
// stepper motion command block: apb byte port, command parser, motion control
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/1ps
`include "step_motion_consts.vh"
module step_motion #(
  parameter TICK_CYCLES = `MCLK_HZ / 1000000 * `TICK_US
) (
  input wire i_mclk,
  input wire i_reset_n,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [31:0] i_paddr,
  input wire [31:0] i_pwdata,
  output wire o_pready,
  output reg [31:0] o_prdata,
  output wire o_pslverr,
  input wire i_home,
  input wire i_limit,
  output reg o_motor_en,
  output wire o_step,
  output reg o_dir_cw
);
  localparam P_PFX = 3'd0;
  localparam P_ADR = 3'd1;
  localparam P_CMD = 3'd2;
  localparam P_ARG = 3'd3;
  localparam P_SKIP = 3'd4;
  localparam K_ABS = 2'd0;
  localparam K_REL = 2'd1;
  localparam K_CONT = 2'd2;
  localparam K_HOME = 2'd3;

  reg [2:0] ctrl_reg;
  reg [15:0] board_reg;
  reg [`VEL_W-1:0] begin_reg;
  reg [`VEL_W-1:0] end_reg;
  reg [`VEL_W-1:0] slope_reg;
  reg [31:0] pos_reg;
  reg [7:0] status_reg;
  reg homed_reg;
  reg home_cw_reg;
  reg [2:0] pstate_reg;
  reg [7:0] cmd_reg;
  reg [1:0] yn_cnt_reg;
  reg yn0_reg;
  reg yn1_reg;
  reg neg_reg;
  reg strip_opt_reg;
  reg strip_reg;
  reg [31:0] num_reg;
  reg running_reg;
  reg [1:0] kind_reg;
  reg away_reg;
  reg [31:0] target_reg;
  reg [31:0] remain_reg;
  reg watch_home_reg;
  reg watch_limit_reg;
  reg speed_chg_reg;
  reg [31:0] resp_reg;
  reg [3:0] resp_cnt_reg;
  reg [1:0] home_sync_reg;
  reg [1:0] limit_sync_reg;
  reg [15:0] tick_cnt_reg;
  reg tick_reg;

  wire setup;
  wire access;
  wire wr;
  wire rd;
  wire [7:0] addr;
  wire [7:0] rx_byte;
  wire rx_we;
  wire is_digit;
  wire [31:0] num_next;
  wire exec;
  wire move_ok;
  wire [31:0] signed_num;
  wire home_trip;
  wire limit_trip;
  wire ramp_step;
  wire at_speed;
  wire stop_now;
  wire mapped;
  wire [3:0] nib;
  wire [7:0] hex_ch;
  reg [3:0] sig_nibs;
  integer k;

  assign setup = i_psel && !i_penable;
  assign access = i_psel && i_penable;
  assign o_pready = access;
  assign addr = i_paddr[7:0];
  assign mapped = (i_paddr[31:8] == 24'h000000) && (addr[1:0] == 2'h0) && (addr <= `ADDR_BOARD);
  assign o_pslverr = access && !mapped;
  assign wr = access && i_pwrite && mapped;
  assign rd = access && !i_pwrite && mapped;
  assign rx_byte = i_pwdata[7:0];
  assign rx_we = wr && addr == `ADDR_RXDATA;
  assign is_digit = rx_byte >= `CH_ZERO && rx_byte <= `CH_NINE;
  assign num_next = {num_reg[28:0], 3'h0} + {num_reg[30:0], 1'b0} + {28'h0000000, rx_byte[3:0] - 4'h0};
  assign exec = rx_we && pstate_reg == P_ARG && rx_byte == `CH_CR;
  assign move_ok = homed_reg || !ctrl_reg[`CTRL_HWLIM_BIT];
  assign signed_num = neg_reg ? (~num_reg + 32'h00000001) : num_reg;
  assign home_trip = home_sync_reg[1] && !ctrl_reg[`CTRL_HOMEDIS_BIT];
  assign limit_trip = !limit_sync_reg[1];
  assign nib = resp_reg[31:28];
  assign hex_ch = (nib < 4'hA) ? (`CH_ZERO + {4'h0, nib}) : (`CH_A_UP + {4'h0, nib} - 8'h0A);

  // how many hex digits are significant, at least one
  always @*
  begin
    sig_nibs = 4'h1;
    for (k = 1; k < 8; k = k + 1)
      if (pos_reg[4*k +: 4] != 4'h0)
        sig_nibs = k[3:0] + 4'h1;
  end

  // stop conditions checked every cycle while moving
  assign stop_now = (kind_reg == K_ABS && pos_reg == target_reg)
    || (kind_reg == K_REL && remain_reg == 32'h00000000)
    || (kind_reg == K_REL && watch_home_reg && home_trip)
    || (kind_reg == K_REL && watch_limit_reg && limit_trip)
    || (kind_reg == K_HOME && (home_trip || ctrl_reg[`CTRL_HOMEDIS_BIT]));

  always @(posedge i_mclk)
  begin
    if (!i_reset_n)
    begin
      home_sync_reg <= 2'h0;
      limit_sync_reg <= 2'h3;
      tick_cnt_reg <= 16'h0000;
      tick_reg <= 1'b0;
    end
    else
    begin
      home_sync_reg <= {home_sync_reg[0], i_home};
      limit_sync_reg <= {limit_sync_reg[0], i_limit};
      tick_reg <= 1'b0;
      if (tick_cnt_reg == TICK_CYCLES[15:0] - 16'h0001)
      begin
        tick_cnt_reg <= 16'h0000;
        tick_reg <= 1'b1;
      end
      else
        tick_cnt_reg <= tick_cnt_reg + 16'h0001;
    end
  end

  // apb read data is captured in the setup cycle
  always @(posedge i_mclk)
  begin
    if (!i_reset_n)
      o_prdata <= 32'h00000000;
    else if (setup && !mapped)
      o_prdata <= 32'h00000000;
    else if (setup)
    begin
      case (addr)
        `ADDR_CTRL: o_prdata <= {29'h0, ctrl_reg};
        `ADDR_TXDATA: o_prdata <= {24'h0, (resp_cnt_reg != 4'h0) ? hex_ch : 8'h00};
        `ADDR_STATUS: o_prdata <= {22'h0, resp_cnt_reg != 4'h0, homed_reg, status_reg};
        `ADDR_POS: o_prdata <= pos_reg;
        `ADDR_BEGIN_VEL: o_prdata <= {16'h0, begin_reg};
        `ADDR_END_VEL: o_prdata <= {16'h0, end_reg};
        `ADDR_SLOPE: o_prdata <= {16'h0, slope_reg};
        `ADDR_BOARD: o_prdata <= {16'h0, board_reg};
        default: o_prdata <= 32'h00000000;
      endcase
    end
  end

  // command parser
  always @(posedge i_mclk)
  begin
    if (!i_reset_n)
    begin
      pstate_reg <= P_PFX;
      cmd_reg <= 8'h00;
      yn_cnt_reg <= 2'h0;
      yn0_reg <= 1'b0;
      yn1_reg <= 1'b1;
      neg_reg <= 1'b0;
      strip_opt_reg <= 1'b0;
      num_reg <= 32'h00000000;
    end
    else if (rx_we)
    begin
      if (rx_byte == `CH_CR)
        pstate_reg <= P_PFX;
      else
      begin
        case (pstate_reg)
          P_PFX: pstate_reg <= (rx_byte == board_reg[7:0]) ? P_ADR : P_SKIP;
          P_ADR: pstate_reg <= (rx_byte == board_reg[15:8]) ? P_CMD : P_SKIP;
          P_CMD:
          begin
            pstate_reg <= P_ARG;
            cmd_reg <= rx_byte;
            yn_cnt_reg <= 2'h0;
            yn0_reg <= 1'b0;
            yn1_reg <= 1'b1;
            neg_reg <= 1'b0;
            strip_opt_reg <= 1'b0;
            num_reg <= 32'h00000000;
          end
          P_ARG:
          begin
            if (is_digit)
              num_reg <= num_next;
            else if (rx_byte == `CH_MINUS)
              neg_reg <= 1'b1;
            else if (rx_byte == `CH_PLUS)
              neg_reg <= 1'b0;
            else if (rx_byte == `CH_S)
              strip_opt_reg <= 1'b1;
            else if (rx_byte == `CH_Y || rx_byte == `CH_N)
            begin
              if (yn_cnt_reg == 2'h0)
                yn0_reg <= rx_byte == `CH_Y;
              else
                yn1_reg <= rx_byte == `CH_Y;
              yn_cnt_reg <= yn_cnt_reg + 2'h1;
            end
          end
          default: pstate_reg <= P_SKIP;
        endcase
      end
    end
  end

  // registers, motion control and response
  always @(posedge i_mclk)
  begin
    if (!i_reset_n)
    begin
      ctrl_reg <= `CTRL_RESET;
      board_reg <= `BOARD_RESET;
      begin_reg <= `BEGIN_RESET;
      end_reg <= `END_RESET;
      slope_reg <= `SLOPE_RESET;
      pos_reg <= 32'h00000000;
      status_reg <= `ST_READY;
      homed_reg <= 1'b0;
      home_cw_reg <= 1'b0;
      strip_reg <= 1'b0;
      running_reg <= 1'b0;
      kind_reg <= K_ABS;
      away_reg <= 1'b0;
      target_reg <= 32'h00000000;
      remain_reg <= 32'h00000000;
      watch_home_reg <= 1'b0;
      watch_limit_reg <= 1'b1;
      speed_chg_reg <= 1'b0;
      resp_reg <= 32'h00000000;
      resp_cnt_reg <= 4'h0;
      o_motor_en <= 1'b0;
      o_dir_cw <= 1'b0;
    end
    else
    begin
      if (wr && addr == `ADDR_CTRL)
        ctrl_reg <= i_pwdata[2:0];
      if (wr && addr == `ADDR_BOARD)
        board_reg <= i_pwdata[15:0];
      if (wr && addr == `ADDR_BEGIN_VEL)
        begin_reg <= i_pwdata[15:0];
      if (wr && addr == `ADDR_SLOPE)
        slope_reg <= i_pwdata[15:0];
      if (wr && addr == `ADDR_END_VEL)
      begin
        end_reg <= i_pwdata[15:0];
        if (running_reg && kind_reg == K_CONT && ctrl_reg[`CTRL_RT_BIT])
        begin
          // keep the end-to-begin offset so the slope profile is unchanged
          begin_reg <= i_pwdata[15:0] - (end_reg - begin_reg);
          speed_chg_reg <= 1'b1;
        end
      end
      if (rd && addr == `ADDR_TXDATA && resp_cnt_reg != 4'h0)
      begin
        resp_reg <= {resp_reg[27:0], 4'h0};
        resp_cnt_reg <= resp_cnt_reg - 4'h1;
      end

      if (running_reg)
      begin
        if (ramp_step && !stop_now)
        begin
          // position simply wraps when a relative move runs past the range
          pos_reg <= away_reg ? pos_reg + 32'h00000001 : pos_reg - 32'h00000001;
          remain_reg <= remain_reg - 32'h00000001;
        end
        if (speed_chg_reg && at_speed)
          speed_chg_reg <= 1'b0;
        status_reg <= (speed_chg_reg && !at_speed) ? `ST_UPDATE : `ST_BUSY;
        if (stop_now)
        begin
          running_reg <= 1'b0;
          o_motor_en <= 1'b0;
          speed_chg_reg <= 1'b0;
          status_reg <= `ST_READY;
          if (kind_reg == K_HOME)
          begin
            pos_reg <= 32'h00000000;
            homed_reg <= 1'b1;
          end
          else if (kind_reg == K_REL && watch_home_reg && home_trip)
            pos_reg <= 32'h00000000;
        end
      end

      if (exec)
      begin
        case (cmd_reg)
          `CMD_MOVE:
            if (move_ok && !running_reg)
            begin
              target_reg <= signed_num;
              away_reg <= $signed(signed_num) > $signed(pos_reg);
              // direction is settled with the enable so it never moves mid-run
              o_dir_cw <= ($signed(signed_num) > $signed(pos_reg)) ? !home_cw_reg : home_cw_reg;
              kind_reg <= K_ABS;
              running_reg <= 1'b1;
              o_motor_en <= 1'b1;
            end
          `CMD_REL:
            if (move_ok && !running_reg)
            begin
              remain_reg <= num_reg;
              away_reg <= !neg_reg;
              o_dir_cw <= neg_reg ? home_cw_reg : !home_cw_reg;
              watch_home_reg <= yn0_reg;
              watch_limit_reg <= yn1_reg;
              kind_reg <= K_REL;
              running_reg <= 1'b1;
              o_motor_en <= 1'b1;
            end
          `CMD_CONT:
            if (move_ok && !running_reg)
            begin
              away_reg <= !neg_reg;
              o_dir_cw <= neg_reg ? home_cw_reg : !home_cw_reg;
              kind_reg <= K_CONT;
              running_reg <= 1'b1;
              o_motor_en <= 1'b1;
            end
          `CMD_HOME:
            if (!running_reg)
            begin
              home_cw_reg <= !neg_reg;
              strip_reg <= strip_opt_reg;
              if (num_reg == 32'h00000000)
              begin
                pos_reg <= 32'h00000000;
                homed_reg <= 1'b1;
                status_reg <= `ST_ZEROED;
              end
              else
              begin
                away_reg <= 1'b0;
                o_dir_cw <= !neg_reg;
                kind_reg <= K_HOME;
                running_reg <= 1'b1;
                o_motor_en <= 1'b1;
              end
            end
          `CMD_GETPOS:
          begin
            resp_cnt_reg <= strip_reg ? sig_nibs : `NIB_DIGITS;
            resp_reg <= strip_reg ? (pos_reg << (`NIB_DIGITS - sig_nibs) * 4) : pos_reg;
          end
          `CMD_ABORT:
          begin
            running_reg <= 1'b0;
            o_motor_en <= 1'b0;
            speed_chg_reg <= 1'b0;
            status_reg <= `ST_READY;
          end
          default: status_reg <= status_reg;
        endcase
      end
    end
  end

  // begin, end and slope shape every move, homing included
  step_ramp u_ramp (
    .i_mclk(i_mclk),
    .i_reset_n(i_reset_n),
    .i_run(running_reg),
    .i_tick(tick_reg),
    .i_begin(begin_reg),
    .i_end(end_reg),
    .i_slope(slope_reg),
    .o_step(ramp_step),
    .o_at_speed(at_speed)
  );

  assign o_step = ramp_step && running_reg;
endmodule // step_motion

// [sim/step_motion_properties.sv]
// port checker for the stepper motion block
`timescale 1ns/1ps
module step_motion_properties #(
  parameter TICK_CYCLES = 40000
) (
  input wire i_mclk,
  input wire i_reset_n,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [31:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire o_pready,
  input wire [31:0] o_prdata,
  input wire o_pslverr,
  input wire i_home,
  input wire i_limit,
  input wire o_motor_en,
  input wire o_step,
  input wire o_dir_cw
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_reset_n);
  wire acc = i_psel && i_penable;
  wire bad = (i_paddr > 32'h20) || (i_paddr[1:0] != 2'h0);
  ready_now_a: assert property (acc |-> o_pready) else $error("pready low in access");
  ready_idle_a: assert property (!acc |-> !o_pready) else $error("pready high when idle");
  err_bad_a: assert property (acc && bad |-> o_pslverr) else $error("no error on unmapped");
  err_good_a: assert property (acc && !bad |-> !o_pslverr) else $error("error on mapped");
  bad_zero_a: assert property (acc && bad && !i_pwrite |-> o_prdata == 32'h0) else $error("unmapped read");
  // read data must outlive the access so a slow master still sees it
  rdata_hold_a: assert property (acc |=> $stable(o_prdata)) else $error("read data moved");
  step_pulse_a: assert property (o_step |=> !o_step) else $error("step pulse too long");
  step_power_a: assert property (o_step |-> o_motor_en) else $error("step without power");
  dir_hold_a: assert property (o_motor_en && $past(o_motor_en) |-> $stable(o_dir_cw)) else $error("dir moved");
  cover property (o_step);
  cover property (acc && o_pslverr);
  cover property ($fell(o_motor_en));
endmodule // step_motion_properties
bind step_motion step_motion_properties #(.TICK_CYCLES(TICK_CYCLES)) u_props (
  .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready),
  .o_prdata(o_prdata), .o_pslverr(o_pslverr), .i_home(i_home), .i_limit(i_limit),
  .o_motor_en(o_motor_en), .o_step(o_step), .o_dir_cw(o_dir_cw));

// [sim/step_motor_model.sv]
// motor and sensor model: counts powered steps and trips the sensors
`timescale 1ns/1ps
module step_motor_model (
  input wire i_mclk,
  input wire i_step,
  input wire i_motor_en,
  input wire i_arm,
  input wire [7:0] i_home_at,
  input wire [7:0] i_limit_at,
  output logic o_home,
  output logic o_limit_n,
  output logic [15:0] o_steps
);
  initial o_steps = 16'h0;
  always @(posedge i_mclk)
    if (i_arm)
      o_steps <= 16'h0;
    else if (i_step && i_motor_en)
      o_steps <= o_steps + 16'h1;
  // a zero trip count means the sensor never fires
  assign o_home = (i_home_at != 8'h0) && (o_steps >= {8'h0, i_home_at});
  assign o_limit_n = !((i_limit_at != 8'h0) && (o_steps >= {8'h0, i_limit_at}));
endmodule // step_motor_model

// [sim/step_motion_test.sv]
// self-checking testbench for the stepper motion block
`timescale 1ns/1ps
`include "step_motion_consts.vh"
module step_motion_test;
  logic mclk, reset_n, psel, penable, pwrite, pready, pslverr, err, arm;
  logic home, limit_n, motor_en, step, dir_cw;
  logic [31:0] paddr, pwdata, prdata, v;
  logic [7:0] home_at, limit_at;
  logic [15:0] steps;
  int mismatches, n_tests, cycles;
  step_motion #(.TICK_CYCLES(4)) i_dut (.i_mclk(mclk), .i_reset_n(reset_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
    .o_prdata(prdata), .o_pslverr(pslverr), .i_home(home), .i_limit(limit_n),
    .o_motor_en(motor_en), .o_step(step), .o_dir_cw(dir_cw));
  step_motor_model i_motor (.i_mclk(mclk), .i_step(step), .i_motor_en(motor_en), .i_arm(arm),
    .i_home_at(home_at), .i_limit_at(limit_at), .o_home(home), .o_limit_n(limit_n), .o_steps(steps));
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // the whole run needs about 7500 cycles
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 80000)
    begin
      mismatches++;
      end_sim();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    // only the bench timeout ends this wait
    while (pready !== 1'b1)
      @(posedge mclk);
    v = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic send(input string s);
    foreach (s[i])
      apb(1'b1, `ADDR_RXDATA, {24'h0, s[i]});
    apb(1'b1, `ADDR_RXDATA, {24'h0, `CH_CR});
  endtask
  // wait for motor power to reach a level; a hang is caught by the check
  task automatic wait_en(input logic lvl);
    int n;
    n = 0;
    while (motor_en !== lvl && n < 20000)
    begin
      n++;
      @(posedge mclk);
    end
    check(motor_en, lvl);
  endtask
  task automatic wait_stat(input logic [7:0] c);
    int n;
    n = 0;
    apb(1'b0, `ADDR_STATUS, 32'h0);
    while (v[7:0] !== c && n < 3000)
    begin
      n++;
      apb(1'b0, `ADDR_STATUS, 32'h0);
    end
  endtask
  task automatic move(input string s, input logic [7:0] h, input logic [7:0] l, input logic d,
    input logic [15:0] n, input logic [31:0] p);
    home_at <= h;
    limit_at <= l;
    arm <= 1'b1;
    @(posedge mclk);
    arm <= 1'b0;
    send(s);
    wait_en(1'b1);
    check(dir_cw, d);
    wait_en(1'b0);
    check(steps, n);
    apb(1'b0, `ADDR_POS, 32'h0);
    check(v, p);
  endtask
  task automatic t_regs;
    apb(1'b0, `ADDR_BOARD, 32'h0);
    check(v, `BOARD_RESET);
    apb(1'b0, `ADDR_SLOPE, 32'h0);
    check(v, `SLOPE_RESET);
    apb(1'b0, 32'h24, 32'h0);
    check(v, 32'h0);
    check({31'h0, err}, 32'h1);
    apb(1'b0, 32'h114, 32'h0);
    check(v, 32'h0);
    check({31'h0, err}, 32'h1);
    apb(1'b1, `ADDR_POS, 32'h77);
    apb(1'b0, `ADDR_POS, 32'h0);
    check(v, 32'h0);
    apb(1'b1, `ADDR_BEGIN_VEL, 32'hFFFF);
    apb(1'b1, `ADDR_END_VEL, 32'hFFFF);
    $display("t_regs done");
  endtask
  task automatic t_unhomed;
    apb(1'b1, `ADDR_CTRL, 32'h2);
    send("b0N+0");
    send("a0RNN+5");
    repeat (40) @(posedge mclk);
    check(motor_en, 1'b0);
    apb(1'b0, `ADDR_STATUS, 32'h0);
    check(v[8], 1'b0);
    send("a0N+0");
    apb(1'b0, `ADDR_STATUS, 32'h0);
    check(v[8:0], {1'b1, `ST_ZEROED});
    $display("t_unhomed done");
  endtask
  task automatic t_moves;
    move("a0RNN+5", 8'h0, 8'h0, 1'b0, 16'h5, 32'h5);
    wait_stat(`ST_READY);
    check(v[7:0], `ST_READY);
    move("a0M3", 8'h0, 8'h0, 1'b1, 16'h2, 32'h3);
    send("a0m");
    for (int i = 0; i < 8; i++)
    begin
      apb(1'b0, `ADDR_TXDATA, 32'h0);
      check(v, (i == 7) ? 32'h33 : 32'h30);
    end
    move("a0RYN+20", 8'h4, 8'h0, 1'b0, 16'h4, 32'h0);
    move("a0RN+20", 8'h0, 8'h3, 1'b0, 16'h3, 32'h3);
    $display("t_moves done");
  endtask
  task automatic t_homing;
    apb(1'b1, `ADDR_CTRL, 32'h4);
    move("a0N-1", 8'h2, 8'h0, 1'b0, 16'h0, 32'h0);
    apb(1'b1, `ADDR_CTRL, 32'h0);
    check(motor_en, 1'b0);
    move("a0N-1", 8'h2, 8'h0, 1'b0, 16'h2, 32'h0);
    move("a0RNN-1", 8'h0, 8'h0, 1'b0, 16'h1, 32'hFFFFFFFF);
    move("a0RNN+1", 8'h0, 8'h0, 1'b1, 16'h1, 32'h0);
    $display("t_homing done");
  endtask
  task automatic t_cont;
    apb(1'b1, `ADDR_CTRL, 32'h1);
    apb(1'b1, `ADDR_BEGIN_VEL, 32'hF000);
    send("a0C+");
    wait_en(1'b1);
    wait_stat(`ST_BUSY);
    check(v[7:0], `ST_BUSY);
    apb(1'b1, `ADDR_END_VEL, 32'hF800);
    apb(1'b0, `ADDR_STATUS, 32'h0);
    check(v[7:0], `ST_UPDATE);
    apb(1'b0, `ADDR_BEGIN_VEL, 32'h0);
    check(v, 32'hE801);
    wait_stat(`ST_BUSY);
    check(v[7:0], `ST_BUSY);
    check(motor_en, 1'b1);
    send("a0A");
    wait_en(1'b0);
    wait_stat(`ST_READY);
    check(v[7:0], `ST_READY);
    $display("t_cont done");
  endtask
  task automatic t_strip;
    send("a0N+0S");
    send("a0m");
    apb(1'b0, `ADDR_TXDATA, 32'h0);
    check(v, 32'h30);
    apb(1'b0, `ADDR_TXDATA, 32'h0);
    check(v, 32'h0);
    $display("t_strip done");
  endtask
  initial
  begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    arm = 1'b0;
    home_at = 8'h0;
    limit_at = 8'h0;
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    t_regs();
    t_unhomed();
    t_moves();
    t_homing();
    t_cont();
    t_strip();
    end_sim();
  end
endmodule // step_motion_test
